// >>> npj_pkg.sv
// Purpose: Shared constants and types for the nibble core load/pointer/jump
//          executor.
// Assumes: Byte-wide program ROM and nibble-wide RAM, both with one cycle of
//          read latency.
// Notes:   Opcode values mirror the instruction encoding of the core.
package npj_pkg;

   // Register map (byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATE = 8'h04;
   localparam logic [7:0] REG_PCSP = 8'h08;
   localparam logic [7:0] REG_FLAGS = 8'h0c;

   // Field positions
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_BUSY_BIT = 1;
   localparam int ST_Y_LSB = 0;
   localparam int ST_X_LSB = 4;
   localparam int ST_L_LSB = 8;
   localparam int ST_H_LSB = 12;
   localparam int ST_AC_LSB = 16;
   localparam int ST_EXT_LSB = 20;
   localparam int ST_ZF_BIT = 24;
   localparam int ST_CF_BIT = 25;
   localparam int ST_BANK_BIT = 26;
   localparam int PS_PC_LSB = 0;
   localparam int PS_SP_LSB = 16;

   // Reset values
   localparam logic [13:0] PC_RESET = 14'h0000;
   localparam logic [7:0] SP_RESET = 8'hff;
   localparam logic [3:0] NIB_RESET = 4'h0;

   // Pointer nibble indices
   localparam logic [1:0] PTR_H = 2'h0;
   localparam logic [1:0] PTR_L = 2'h1;
   localparam logic [1:0] PTR_X = 2'h2;
   localparam logic [1:0] PTR_Y = 2'h3;

   // Stack frame size in nibbles
   localparam logic [7:0] STACK_FRAME = 8'h04;

   // Single and first-byte opcodes, then second-byte selector fields
   localparam logic [7:0] OP_BANK = 8'h1b;
   localparam logic [7:0] OP_INC_L = 8'h11;
   localparam logic [7:0] OP_DEC_L = 8'h21;
   localparam logic [7:0] OP_INC_Y = 8'h13;
   localparam logic [7:0] OP_DEC_Y = 8'h23;
   localparam logic [7:0] OP_COMPUTED_PAGE_JUMP = 8'h27;
   localparam logic [7:0] OP_ROM_TABLE_FETCH = 8'h5a;
   localparam logic [7:0] OP_ROM_TABLE_TO_PORTS = 8'h58;
   localparam logic [7:0] OP_LHI = 8'hc0;
   localparam logic [7:0] OP_LLI = 8'hc1;
   localparam logic [7:0] OP_POINTER_HL_PAIR_LOAD = 8'hc2;
   localparam logic [7:0] OP_POINTER_XY_PAIR_LOAD = 8'hc4;
   localparam logic [7:0] OP_LOAD_PAIR_IMMEDIATE = 8'hc6;
   localparam logic [7:0] OP_SWAP_WORK_WITH_DIRECT_MEM = 8'hc8;
   localparam logic [7:0] OP_TPA = 8'hce;
   localparam logic [7:0] OP_TAP = 8'hcf;
   localparam logic [3:0] SUB_NIB_IMM = 4'hf;
   localparam logic [5:0] SUB_PTR_SEL = 6'h3c;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [8:0] {
      S_IDLE = 9'h001,
      S_FETCH = 9'h002,
      S_OP = 9'h004,
      S_OP2 = 9'h008,
      S_MWAIT = 9'h010,
      S_MEM = 9'h020,
      S_PUSH = 9'h040,
      S_TWAIT = 9'h080,
      S_TBL = 9'h100
   } npj_state_t;

   typedef struct packed {
      logic [8:0] addr;
      logic we;
      logic [3:0] wdata;
   } npj_ram_req_t;

endpackage

// >>> npj_core.sv
// Purpose: Executes loads, exchanges, pointer, flag, jump and call
//          instructions of a 4-bit core, with an AXI4-Lite debug port.
// Assumes: ROM and RAM return data one cycle after the address flop.
// Notes:   Unknown opcodes complete as no-ops.
`timescale 1ns/1ps
module npj_core #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Program ROM
   output logic [13:0] romAddr,
   input wire logic [7:0] romData,
   // Data RAM
   output npj_pkg::npj_ram_req_t ramReq,
   input wire logic [3:0] ramRdata,
   // Output ports 4 and 5, bank indicator
   output logic [3:0] port4,
   output logic [3:0] port5,
   output logic bankSel,
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   npj_pkg::npj_state_t state;
   logic [13:0] pc;
   logic [7:0] sp;
   logic [3:0] ac;
   logic [3:0] ext;
   logic [3:0] ptr [4];
   logic [15:0] userFlag;
   logic zf;
   logic cf;
   logic [7:0] opcode;
   logic second;
   logic bankArm;
   logic bankActive;
   logic memSwap;
   logic memStep;
   logic memDown;
   logic memUseY;
   logic tblToPort;
   logic [13:0] pushTarget;
   logic [1:0] pushCnt;
   logic run;
   // Bus write staging
   logic awFull;
   logic wFull;
   logic [ADDR_W-1:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic wrEn;
   logic [7:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic next_awFull;
   logic next_wFull;
   logic doWrite;
   logic [13:0] pcNext;
   logic [1:0] stepIdx;
   logic [3:0] stepVal;

   function automatic logic [3:0] stepNib(input logic [3:0] v,
                                          input logic down);
      stepNib = down ? v - 4'h1 : v + 4'h1;
   endfunction

   function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      mergeStrb = r;
   endfunction

   function automatic logic [31:0] readReg(input logic [7:0] a,
                                           input logic [31:0] stateWord,
                                           input logic [31:0] pcspWord,
                                           input logic [31:0] ctrlWord,
                                           input logic [31:0] flagWord);
      case ({a[7:2], 2'b00})
         npj_pkg::REG_CTRL: readReg = ctrlWord;
         npj_pkg::REG_STATE: readReg = stateWord;
         npj_pkg::REG_PCSP: readReg = pcspWord;
         npj_pkg::REG_FLAGS: readReg = flagWord;
         default: readReg = 32'h0000_0000;
      endcase
   endfunction

   function automatic logic isMapped(input logic [7:0] a);
      isMapped = ({a[7:2], 2'b00} == npj_pkg::REG_CTRL) ||
                 ({a[7:2], 2'b00} == npj_pkg::REG_STATE) ||
                 ({a[7:2], 2'b00} == npj_pkg::REG_PCSP) ||
                 ({a[7:2], 2'b00} == npj_pkg::REG_FLAGS);
   endfunction

   logic [31:0] stateWord;
   logic [31:0] pcspWord;
   logic [31:0] ctrlWord;
   logic [31:0] flagWord;

   always_comb begin
      stateWord = 32'h0000_0000;
      stateWord[npj_pkg::ST_Y_LSB +: 4] = ptr[npj_pkg::PTR_Y];
      stateWord[npj_pkg::ST_X_LSB +: 4] = ptr[npj_pkg::PTR_X];
      stateWord[npj_pkg::ST_L_LSB +: 4] = ptr[npj_pkg::PTR_L];
      stateWord[npj_pkg::ST_H_LSB +: 4] = ptr[npj_pkg::PTR_H];
      stateWord[npj_pkg::ST_AC_LSB +: 4] = ac;
      stateWord[npj_pkg::ST_EXT_LSB +: 4] = ext;
      stateWord[npj_pkg::ST_ZF_BIT] = zf;
      stateWord[npj_pkg::ST_CF_BIT] = cf;
      stateWord[npj_pkg::ST_BANK_BIT] = bankActive;
      pcspWord = 32'h0000_0000;
      pcspWord[npj_pkg::PS_PC_LSB +: 14] = pc;
      pcspWord[npj_pkg::PS_SP_LSB +: 8] = sp;
      ctrlWord = 32'h0000_0000;
      ctrlWord[npj_pkg::CTRL_RUN_BIT] = run;
      ctrlWord[npj_pkg::CTRL_BUSY_BIT] = (state != npj_pkg::S_IDLE);
      flagWord = {16'h0000, userFlag};
   end

   // Write channel acceptance, either order; response after both
   always_comb begin
      doWrite = awFull && wFull && !s_axi_bvalid;
      next_awFull = doWrite ? 1'b0 : (awFull || s_axi_awvalid);
      next_wFull = doWrite ? 1'b0 : (wFull || s_axi_wvalid);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         awFull <= 1'b0;
         wFull <= 1'b0;
         awAddr <= '0;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= npj_pkg::RESP_OKAY;
         wrEn <= 1'b0;
         wrAddr <= 8'h00;
         wrData <= 32'h0000_0000;
         wrStrb <= 4'h0;
         run <= 1'b0;
      end else begin
         wrEn <= 1'b0;
         awFull <= next_awFull;
         wFull <= next_wFull;
         s_axi_awready <= !next_awFull;
         s_axi_wready <= !next_wFull;
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= isMapped(8'(awAddr)) ? npj_pkg::RESP_OKAY
                                                : npj_pkg::RESP_SLVERR;
            wrEn <= isMapped(8'(awAddr));
            wrAddr <= {awAddr[7:2], 2'b00};
            wrData <= wData;
            wrStrb <= wStrb;
            if ({awAddr[7:2], 2'b00} == npj_pkg::REG_CTRL && wStrb[0]) begin
               run <= wData[npj_pkg::CTRL_RUN_BIT];
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel: one outstanding read
   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= npj_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= readReg(8'(s_axi_araddr), stateWord, pcspWord,
                                ctrlWord, flagWord);
         s_axi_rresp <= isMapped(8'(s_axi_araddr)) ? npj_pkg::RESP_OKAY
                                                   : npj_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end else begin
         s_axi_arready <= !s_axi_rvalid;
      end
   end

   always_comb begin
      pcNext = pc + 14'h0001;
      stepIdx = memUseY ? npj_pkg::PTR_Y : npj_pkg::PTR_L;
      stepVal = stepNib(ptr[stepIdx], memDown);
   end

   // Instruction sequencer and architectural state
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= npj_pkg::S_IDLE;
         pc <= npj_pkg::PC_RESET;
         sp <= npj_pkg::SP_RESET;
         ac <= npj_pkg::NIB_RESET;
         ext <= npj_pkg::NIB_RESET;
         for (int i = 0; i < 4; i++) begin
            ptr[i] <= npj_pkg::NIB_RESET;
         end
         userFlag <= 16'h0000;
         zf <= 1'b0;
         cf <= 1'b0;
         opcode <= 8'h00;
         second <= 1'b0;
         bankArm <= 1'b0;
         bankActive <= 1'b0;
         memSwap <= 1'b0;
         memStep <= 1'b0;
         memDown <= 1'b0;
         memUseY <= 1'b0;
         tblToPort <= 1'b0;
         pushTarget <= npj_pkg::PC_RESET;
         pushCnt <= 2'h0;
         romAddr <= npj_pkg::PC_RESET;
         ramReq <= '0;
         port4 <= 4'h0;
         port5 <= 4'h0;
         bankSel <= 1'b0;
      end else begin
         ramReq.we <= 1'b0;
         case (state)
            npj_pkg::S_IDLE: begin
               if (run) begin
                  romAddr <= pc;
                  state <= npj_pkg::S_FETCH;
               end
            end
            npj_pkg::S_FETCH: begin
               state <= second ? npj_pkg::S_OP2 : npj_pkg::S_OP;
            end
            npj_pkg::S_OP: begin
               opcode <= romData;
               pc <= pcNext;
               state <= npj_pkg::S_IDLE;
               bankActive <= bankArm;
               bankSel <= bankArm;
               bankArm <= (romData == npj_pkg::OP_BANK);
               memUseY <= romData[1];
               memSwap <= romData[2];
               memStep <= romData[0];
               memDown <= romData[4];
               casez (romData)
                  8'b010?_1??1, 8'b0100_11?0: begin
                     // Memory at HL or XY, then optional swap/step
                     ramReq.addr <= {bankArm, romData[1] ?
                        {ptr[npj_pkg::PTR_X], ptr[npj_pkg::PTR_Y]} :
                        {ptr[npj_pkg::PTR_H], ptr[npj_pkg::PTR_L]}};
                     state <= npj_pkg::S_MWAIT;
                  end
                  npj_pkg::OP_ROM_TABLE_FETCH, npj_pkg::OP_ROM_TABLE_TO_PORTS: begin
                     romAddr <= {pc[13:8], ext, ac};
                     tblToPort <= !romData[1];
                     state <= npj_pkg::S_TWAIT;
                  end
                  8'b0110_????: begin
                     ptr[npj_pkg::PTR_H] <= 4'h0;
                     ptr[npj_pkg::PTR_L] <= romData[3:0];
                  end
                  npj_pkg::OP_INC_L, npj_pkg::OP_DEC_L,
                  npj_pkg::OP_INC_Y, npj_pkg::OP_DEC_Y: begin
                     ptr[{romData[1], 1'b1}] <= stepNib(ptr[{romData[1], 1'b1}],
                                                        romData[5]);
                     zf <= stepNib(ptr[{romData[1], 1'b1}], romData[5])
                           == 4'h0;
                  end
                  8'b0100_00??: begin
                     ptr[romData[1:0]] <= ac;
                     ac <= ptr[romData[1:0]];
                  end
                  8'b0111_????: begin
                     userFlag[romData[3:0]] <= 1'b1;
                  end
                  8'b0011_????: begin
                     userFlag[romData[3:0]] <= 1'b0;
                     zf <= !userFlag[romData[3:0]];
                  end
                  npj_pkg::OP_COMPUTED_PAGE_JUMP: begin
                     pc <= {pc[13:8], ext, ac};
                  end
                  8'b1010_????: begin
                     pushTarget <= {8'h00, romData[3:0], 2'b00};
                     pushCnt <= 2'h0;
                     state <= npj_pkg::S_PUSH;
                  end
                  8'b1110_????, 8'b0101_0???, npj_pkg::OP_LHI,
                  npj_pkg::OP_LLI, npj_pkg::OP_POINTER_HL_PAIR_LOAD, npj_pkg::OP_POINTER_XY_PAIR_LOAD,
                  npj_pkg::OP_LOAD_PAIR_IMMEDIATE, npj_pkg::OP_SWAP_WORK_WITH_DIRECT_MEM, npj_pkg::OP_TPA,
                  npj_pkg::OP_TAP: begin
                     second <= 1'b1;
                     romAddr <= pcNext;
                     state <= npj_pkg::S_FETCH;
                  end
                  default: begin
                  end
               endcase
            end
            npj_pkg::S_OP2: begin
               second <= 1'b0;
               pc <= pcNext;
               state <= npj_pkg::S_IDLE;
               casez (opcode)
                  8'b1110_????: begin
                     pc <= {pc[13], pc[12] ^ bankActive,
                            opcode[3:0], romData};
                  end
                  8'b0101_0???: begin
                     pushTarget <= {3'b000, opcode[2:0], romData};
                     pushCnt <= 2'h0;
                     state <= npj_pkg::S_PUSH;
                  end
                  npj_pkg::OP_LHI, npj_pkg::OP_LLI: begin
                     if (romData[7:4] == npj_pkg::SUB_NIB_IMM) begin
                        ptr[{1'b0, opcode[0]}] <= romData[3:0];
                     end
                  end
                  npj_pkg::OP_POINTER_HL_PAIR_LOAD, npj_pkg::OP_POINTER_XY_PAIR_LOAD: begin
                     ptr[{opcode[2], 1'b0}] <= romData[7:4];
                     ptr[{opcode[2], 1'b1}] <= romData[3:0];
                  end
                  npj_pkg::OP_LOAD_PAIR_IMMEDIATE: begin
                     ext <= romData[7:4];
                     ac <= romData[3:0];
                  end
                  npj_pkg::OP_SWAP_WORK_WITH_DIRECT_MEM: begin
                     ramReq.addr <= {bankActive, romData};
                     memSwap <= 1'b1;
                     memStep <= 1'b0;
                     state <= npj_pkg::S_MWAIT;
                  end
                  npj_pkg::OP_TAP: begin
                     if (romData[7:2] == npj_pkg::SUB_PTR_SEL) begin
                        ptr[romData[1:0]] <= ac;
                     end
                  end
                  npj_pkg::OP_TPA: begin
                     if (romData[7:2] == npj_pkg::SUB_PTR_SEL) begin
                        ac <= ptr[romData[1:0]];
                        zf <= ptr[romData[1:0]] == 4'h0;
                     end
                  end
                  default: begin
                  end
               endcase
            end
            npj_pkg::S_MWAIT: begin
               state <= npj_pkg::S_MEM;
            end
            npj_pkg::S_MEM: begin
               ac <= ramRdata;
               if (memSwap) begin
                  ramReq.we <= 1'b1;
                  ramReq.wdata <= ac;
               end
               if (memStep) begin
                  ptr[stepIdx] <= stepVal;
                  zf <= stepVal == 4'h0;
               end
               state <= npj_pkg::S_IDLE;
            end
            npj_pkg::S_PUSH: begin
               // Frame: pc low nibbles first, flags with pc top last
               ramReq.we <= 1'b1;
               ramReq.addr <= {1'b0, sp - 8'h01 - {6'h00, pushCnt}};
               case (pushCnt)
                  2'h0: ramReq.wdata <= pc[3:0];
                  2'h1: ramReq.wdata <= pc[7:4];
                  2'h2: ramReq.wdata <= pc[11:8];
                  default: ramReq.wdata <= {cf, zf, pc[13:12]};
               endcase
               pushCnt <= pushCnt + 2'h1;
               if (pushCnt == 2'h3) begin
                  sp <= sp - npj_pkg::STACK_FRAME;
                  pc <= pushTarget;
                  state <= npj_pkg::S_IDLE;
               end
            end
            npj_pkg::S_TWAIT: begin
               state <= npj_pkg::S_TBL;
            end
            npj_pkg::S_TBL: begin
               if (tblToPort) begin
                  port4 <= romData[7:4];
                  port5 <= romData[3:0];
               end else begin
                  ext <= romData[7:4];
                  ac <= romData[3:0];
               end
               state <= npj_pkg::S_IDLE;
            end
            default: begin
               state <= npj_pkg::S_IDLE;
            end
         endcase
         // Debug loads from the bus take effect last
         if (wrEn && wrAddr == npj_pkg::REG_PCSP) begin
            pc <= 14'(mergeStrb(pcspWord, wrData, wrStrb));
            sp <= 8'(mergeStrb(pcspWord, wrData, wrStrb) >>
                     npj_pkg::PS_SP_LSB);
         end
         if (wrEn && wrAddr == npj_pkg::REG_FLAGS) begin
            userFlag <= 16'(mergeStrb(flagWord, wrData, wrStrb));
         end
      end
   end

endmodule // npj_core

// >>> npj_core_assertions.sv
// Purpose: Port checks for npj_core
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every npj_core instance
`timescale 1ns/1ps
module npj_core_assertions (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // ROM data and output ports
   input wire logic [7:0] romData,
   input wire logic [3:0] port4,
   input wire logic [3:0] port5,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence sWrTaken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence sWrAnswer;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   chk_wr_latency: assert property (sWrTaken |=> sWrAnswer)
      else $error("write response not two cycles after accept");
   chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response held after handshake");
   chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not one cycle after accept");
   chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped or changed early");
   chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data held after handshake");
   chk_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   chk_port_load: assert property ($changed({port4, port5})
      |-> {port4, port5} == $past(romData))
      else $error("ports changed to a value not read from ROM");
endmodule // npj_core_assertions
bind npj_core npj_core_assertions u_npj_core_assertions (.clk, .rst,
   .romData, .port4, .port5, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// >>> npj_core_tb_top.sv
// Purpose: Runs short programs on npj_core and checks the results
// Assumes: Core is started and stopped through the register bus
// Notes: ROM and RAM models have one cycle of read latency
`timescale 1ns/1ps
module npj_core_tb_top;
   logic clk, rst, bankSel;
   logic [13:0] romAddr;
   logic [7:0] romData, s_axi_awaddr, s_axi_araddr;
   npj_pkg::npj_ram_req_t ramReq;
   logic [3:0] ramRdata, port4, port5, s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [7:0] rom [16384];
   logic [3:0] ram [512];
   int failCount, nCompared;
   npj_core u_npj_core (.clk, .rst, .romAddr, .romData, .ramReq, .ramRdata,
      .port4, .port5, .bankSel, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) romData <= rom[romAddr];
   always @(posedge clk) begin
      ramRdata <= ram[ramReq.addr];
      if (ramReq.we) ram[ramReq.addr] <= ramReq.wdata;
   end
   task automatic stopTest();
      $display("Comparisons %0d, mismatches %0d", nCompared, failCount);
      if (failCount == 0 && nCompared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      nCompared++;
      if (seen !== exp) begin
         failCount++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic hang();
      failCount++;
      $display("Error wait limit reached");
      stopTest();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (i == 50) hang();
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int i;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         d = s_axi_rdata;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (i == 50) hang();
      @(posedge clk);
   endtask
   task automatic load(input logic [13:0] a, input logic [7:0] q[$]);
      foreach (q[i]) rom[a + 14'(i)] = q[i];
   endtask
   // Start at address zero, wait for the end loop, then halt
   task automatic runProg(input logic [13:0] endPc);
      logic [31:0] d;
      int i;
      wr(npj_pkg::REG_PCSP, 32'h00ff0000);
      wr(npj_pkg::REG_CTRL, 32'h00000001);
      for (i = 0; i < 100; i++) begin
         rd(npj_pkg::REG_PCSP, d);
         if (d[13:0] === endPc) break;
      end
      chk("pc", {18'h0, d[13:0]}, {18'h0, endPc});
      wr(npj_pkg::REG_CTRL, 32'h00000000);
      for (i = 0; i < 100; i++) begin
         rd(npj_pkg::REG_CTRL, d);
         if (d[1] === 1'b0) break;
      end
      if (i == 100) hang();
   endtask
   task automatic testLoadStep();
      logic [31:0] d;
      ram[9'h03f] = 4'h7;
      load(14'h0000, {8'hc2, 8'h3f, 8'hc6, 8'ha5, 8'h49, 8'hc4, 8'h12,
         8'he0, 8'h07});
      runProg(14'h0007);
      rd(npj_pkg::REG_STATE, d);
      chk("state", {5'h0, d[26:0]}, 32'h01a73012);
      $display("Load and step test done");
   endtask
   task automatic testSwap();
      logic [31:0] d;
      ram[9'h004] = 4'h6;
      load(14'h0000, {8'h64, 8'hc6, 8'h09, 8'h5d, 8'h23, 8'h42, 8'he0, 8'h06});
      runProg(14'h0006);
      rd(npj_pkg::REG_STATE, d);
      chk("state", {5'h0, d[26:0]}, 32'h00010361);
      chk("mem", {28'h0, ram[9'h004]}, 32'h00000009);
      $display("Swap test done");
   endtask
   task automatic testFlagJump();
      logic [31:0] d;
      load(14'h0000, {8'h7c, 8'h75, 8'h35, 8'hc6, 8'h30, 8'h27});
      load(14'h0030, {8'h1b, 8'he0, 8'h40});
      load(14'h1040, {8'he0, 8'h40});
      runProg(14'h1040);
      chk("bank", {31'h0, bankSel}, 32'h00000000);
      rd(npj_pkg::REG_FLAGS, d);
      chk("flags", d, 32'h00001000);
      rd(npj_pkg::REG_STATE, d);
      chk("zero", {31'h0, d[24]}, 32'h00000000);
      chk("bankbit", {31'h0, d[26]}, 32'h00000000);
      $display("Flag and jump test done");
   endtask
   task automatic testCallTable();
      logic [31:0] d;
      load(14'h0080, {8'h5c});
      load(14'h0000, {8'hc6, 8'h80, 8'h58, 8'ha3});
      load(14'h000c, {8'he0, 8'h0c});
      runProg(14'h000c);
      chk("ports", {24'h0, port4, port5}, 32'h0000005c);
      chk("stack", {28'h0, ram[9'h0fe]}, 32'h00000004);
      rd(npj_pkg::REG_PCSP, d);
      chk("sp", {24'h0, d[23:16]}, 32'h000000fb);
      $display("Call and table test done");
   endtask
   task automatic testMisc();
      logic [31:0] d;
      rom[14'h0081] = 8'h93;
      ram[9'h020] = 4'hb;
      ram[9'h06b] = 4'he;
      load(14'h0000, {8'hc6, 8'h81, 8'h5a, 8'hc8, 8'h20, 8'hcf, 8'hf3,
         8'hc1, 8'hf5, 8'h4c, 8'h5b, 8'h50, 8'h20});
      load(14'h0020, {8'he0, 8'h20});
      runProg(14'h0020);
      rd(npj_pkg::REG_STATE, d);
      chk("state", {5'h0, d[26:0]}, 32'h009e056a);
      chk("direct", {28'h0, ram[9'h020]}, 32'h00000003);
      chk("xa", {28'h0, ram[9'h005]}, 32'h0000000b);
      chk("ret", {28'h0, ram[9'h0fe]}, 32'h0000000d);
      $display("Misc test done");
   endtask
   initial begin
      rst = 1'b1;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      failCount = 0;
      nCompared = 0;
      foreach (rom[i]) rom[i] = 8'h00;
      foreach (ram[i]) ram[i] = 4'h0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      testLoadStep();
      testSwap();
      testFlagJump();
      testCallTable();
      testMisc();
      stopTest();
   end
endmodule // npj_core_tb_top
